// file: rtl/gtc_pkg.sv
// Constants shared by the gated 16-bit timer/counter: register map, fields, resets, timing.
// Assumes a 32-bit Avalon-MM slave port with byte addressing and one clock at 10 MHz.
package gtc_pkg;
  // Byte addresses of the registers on the slave port.
  localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_GATE_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h08;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h0C;
  localparam logic [4:0] ADDR_FLAGS = 5'h10;
  // Field positions in timer_control_reg.
  localparam int TC_ON = 0;
  localparam int TC_SYNC_DIS = 2;
  localparam int TC_PRESC_LO = 4;
  localparam int TC_CLKSEL_LO = 6;
  // Field positions in gate_control_reg.
  localparam int GC_SRC_SEL = 0;
  localparam int GC_VALUE = 2;
  localparam int GC_GO = 3;
  localparam int GC_SPM = 4;
  localparam int GC_TOGGLE = 5;
  localparam int GC_POL = 6;
  localparam int GC_ENABLE = 7;
  // Field positions in the flag register.
  localparam int FL_OVERFLOW = 0;
  localparam int FL_GATE_EVENT = 1;
  // Clock select encodings.
  localparam logic [1:0] CLK_INSTR = 2'h0;
  localparam logic [1:0] CLK_SYS = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  localparam logic [1:0] CLK_LFOSC = 2'h3;
  // Reset values and the count and byte timer limits.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_TIMER_MAX = 8'hFF;
  localparam logic [7:0] BYTE_TIMER_MIN = 8'h00;
  // Timing: system clock period and the instruction clock divide ratio.
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int INSTR_PERIOD_NS = 400;
  localparam int INSTR_DIV_CYCLES = INSTR_PERIOD_NS / SYS_CLK_PERIOD_NS;
  // Single-pulse acquisition states, Gray coded along idle, armed, counting.
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ARMED = 2'b01,
    SP_COUNT = 2'b11
  } sp_state_t;
endpackage

// file: rtl/gated_timer_counter.sv
// Gated 16-bit timer/counter with selectable clock, prescaler, gate polarity, toggle and single pulse.
// Assumes all pins except the external clock, gate and oscillator pins are synchronous to sys_clk_in and a 32-bit Avalon-MM master with waitrequest.
`timescale 1ns/100ps
module gated_timer_counter #(
  parameter int INSTR_DIV = gtc_pkg::INSTR_DIV_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ext_clock_pin_in,
  input wire logic gate_pin_in,
  input wire logic low_freq_internal_osc_in,
  input wire logic [7:0] byte_timer_count_in,
  input wire logic sleep_in,
  output logic overflow_flag_out,
  output logic gate_event_flag_out,
  output logic gate_value_out
);
  import gtc_pkg::*;

  // The divider counter is eight bits wide, so larger ratios cannot be served.
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV must lie between 1 and 256.");
  end

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_DIV - 1);

  // Software-visible control state.
  logic [1:0] clock_select_field; // Count clock source.
  logic [1:0] prescale_field; // Prescale ratio as a power of two.
  logic sync_disable_bit; // High bypasses the external clock and gate pin synchronisers.
  logic timer_on_bit; // Master enable.
  logic gate_enable_bit; // High makes the gate control counting.
  logic gate_polarity_bit; // High counts while the gate is high.
  logic toggle_mode_enable; // Gate passes through the toggle flip-flop.
  logic single_pulse_enable; // Gate passes through the single-pulse control.
  logic gate_source_select; // Low picks the gate pin, high the wrap pulse.
  logic pulse_go_bit; // Single-pulse go, cleared by hardware when done.
  logic overflow_flag; // Sticky count wrap flag.
  logic gate_event_flag; // Sticky gate completion flag.
  logic [15:0] count; // Live count, high and low byte.

  // Bus handshake state.
  logic ack; // High in the cycle in which waitrequest is released.
  logic acc_req; // Master asks for an access.
  logic acc_take; // Access completes at this edge.
  logic wr_take; // Write with the low lane enabled completes now.

  // Synchronisers and edge history.
  logic ext_s1, ext_s2, ext_prev;
  logic gate_s1, gate_s2;
  logic lf_s1, lf_s2, lf_prev;
  logic [7:0] byte_timer_prev;
  logic ext_level, gate_level;
  logic ext_rise, ext_fall, lf_rise;
  logic ext_armed; // A falling edge has been seen since the last disarm.

  // Clock path.
  logic [7:0] instr_cnt;
  logic instr_tick;
  logic src_tick;
  logic [2:0] presc_cnt;
  logic presc_hit;
  logic count_en;
  logic inc;

  // Gate path.
  logic byte_timer_wrap_pulse;
  logic gate_src, gate_pol, gate_pol_prev;
  logic toggle_ff, toggle_out, toggle_prev;
  logic gate_value, gate_value_prev;
  sp_state_t sp_state, next_sp_state;
  logic sp_done;
  logic wr_gate_ctrl;

  // Waitrequest is held for one cycle of each access so read data can be registered.
  assign acc_req = avs_read_in | avs_write_in;
  assign acc_take = acc_req & ack;
  assign wr_take = avs_write_in & ack & avs_byteenable_in[0];
  assign avs_waitrequest_out = acc_req & ~ack;
  assign wr_gate_ctrl = wr_take && avs_address_in == ADDR_GATE_CONTROL;

  // Handshake flop: rises one cycle after a request arrives, falls after completion.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack <= 1'b0;
    end else begin
      ack <= acc_req & ~ack;
    end
  end

  // Read data is captured while waitrequest is high, so it stands at the completing edge.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack) begin
      case (avs_address_in)
        ADDR_TIMER_CONTROL: avs_readdata_out <= {24'h00_0000, clock_select_field, prescale_field,
                                                 1'b0, sync_disable_bit, 1'b0, timer_on_bit};
        ADDR_GATE_CONTROL: avs_readdata_out <= {24'h00_0000, gate_enable_bit, gate_polarity_bit,
                                                toggle_mode_enable, single_pulse_enable, pulse_go_bit,
                                                gate_value, 1'b0, gate_source_select};
        ADDR_COUNT_LOW: avs_readdata_out <= {24'h00_0000, count[7:0]};
        ADDR_COUNT_HIGH: avs_readdata_out <= {24'h00_0000, count[15:8]};
        ADDR_FLAGS: avs_readdata_out <= {30'h0000_0000, gate_event_flag, overflow_flag};
        // Unmapped addresses read as zero.
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Timer control register.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clock_select_field <= CLK_INSTR;
      prescale_field <= 2'h0;
      sync_disable_bit <= 1'b0;
      timer_on_bit <= 1'b0;
    end else if (wr_take && avs_address_in == ADDR_TIMER_CONTROL) begin
      clock_select_field <= avs_writedata_in[TC_CLKSEL_LO +: 2];
      prescale_field <= avs_writedata_in[TC_PRESC_LO +: 2];
      sync_disable_bit <= avs_writedata_in[TC_SYNC_DIS];
      timer_on_bit <= avs_writedata_in[TC_ON];
    end
  end

  // Gate control register, apart from the go bit.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gate_enable_bit <= 1'b0;
      gate_polarity_bit <= 1'b0;
      toggle_mode_enable <= 1'b0;
      single_pulse_enable <= 1'b0;
      gate_source_select <= 1'b0;
    end else if (wr_gate_ctrl) begin
      gate_enable_bit <= avs_writedata_in[GC_ENABLE];
      gate_polarity_bit <= avs_writedata_in[GC_POL];
      toggle_mode_enable <= avs_writedata_in[GC_TOGGLE];
      single_pulse_enable <= avs_writedata_in[GC_SPM];
      gate_source_select <= avs_writedata_in[GC_SRC_SEL];
    end
  end

  // Go bit: a software write takes priority over the hardware done clear, so a re-arm is not lost.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pulse_go_bit <= 1'b0;
    end else if (wr_gate_ctrl) begin
      pulse_go_bit <= avs_writedata_in[GC_GO];
    end else if (sp_done) begin
      pulse_go_bit <= 1'b0;
    end
  end

  // Sticky flags: write one to clear, and a hardware set in the same cycle wins.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overflow_flag <= 1'b0;
      gate_event_flag <= 1'b0;
    end else begin
      if (inc && count == COUNT_MAX) begin
        overflow_flag <= 1'b1;
      end else if (wr_take && avs_address_in == ADDR_FLAGS && avs_writedata_in[FL_OVERFLOW]) begin
        overflow_flag <= 1'b0;
      end
      if (gate_value_prev && !gate_value) begin
        gate_event_flag <= 1'b1;
      end else if (wr_take && avs_address_in == ADDR_FLAGS && avs_writedata_in[FL_GATE_EVENT]) begin
        gate_event_flag <= 1'b0;
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
    end else begin
      ext_s1 <= ext_clock_pin_in;
      ext_s2 <= ext_s1;
      gate_s1 <= gate_pin_in;
      gate_s2 <= gate_s1;
      lf_s1 <= low_freq_internal_osc_in;
      lf_s2 <= lf_s1;
    end
  end

  // Async mode takes the external clock and gate pins directly; this trades metastability margin for two cycles of latency.
  assign ext_level = sync_disable_bit ? ext_clock_pin_in : ext_s2;
  assign gate_level = sync_disable_bit ? gate_pin_in : gate_s2;

  // Edge history for the external clock, the oscillator and the byte timer.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_prev <= 1'b0;
      lf_prev <= 1'b0;
      byte_timer_prev <= RESET_BYTE;
    end else begin
      ext_prev <= ext_level;
      lf_prev <= lf_s2;
      byte_timer_prev <= byte_timer_count_in;
    end
  end

  assign ext_rise = ext_level & ~ext_prev;
  assign ext_fall = ~ext_level & ext_prev;
  assign lf_rise = lf_s2 & ~lf_prev;

  // Counter-mode arming: disarmed at reset, on a count write and while off; a falling edge re-arms.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_armed <= 1'b0;
    end else if (!timer_on_bit || (wr_take && (avs_address_in == ADDR_COUNT_LOW ||
                                              avs_address_in == ADDR_COUNT_HIGH))) begin
      ext_armed <= 1'b0;
    end else if (ext_fall) begin
      ext_armed <= 1'b1;
    end
  end

  // Instruction clock divider: one pulse every INSTR_DIV system clocks.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      instr_cnt <= 8'h00;
    end else if (instr_cnt == INSTR_LAST) begin
      instr_cnt <= 8'h00;
    end else begin
      instr_cnt <= instr_cnt + 8'h01;
    end
  end

  assign instr_tick = instr_cnt == INSTR_LAST;

  // Source tick; during sleep only the unsynchronised external clock keeps running.
  always_comb begin
    src_tick = 1'b0;
    case (clock_select_field)
      CLK_INSTR: src_tick = instr_tick;
      CLK_SYS: src_tick = 1'b1;
      CLK_EXT: src_tick = ext_rise & ext_armed;
      CLK_LFOSC: src_tick = lf_rise;
      default: src_tick = 1'b0;
    endcase
    if (sleep_in && !(clock_select_field == CLK_EXT && sync_disable_bit)) begin
      src_tick = 1'b0;
    end
  end

  // Hidden prescale counter, cleared by any count byte write.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_cnt <= 3'h0;
    end else if (wr_take && (avs_address_in == ADDR_COUNT_LOW || avs_address_in == ADDR_COUNT_HIGH)) begin
      presc_cnt <= 3'h0;
    end else if (!timer_on_bit) begin
      presc_cnt <= 3'h0;
    end else if (src_tick) begin
      presc_cnt <= presc_hit ? 3'h0 : presc_cnt + 3'h1;
    end
  end

  // A compare by magnitude lets a running prescaler wrap at once when a smaller ratio is written.
  assign presc_hit = presc_cnt >= 3'((4'h1 << prescale_field) - 4'h1);

  // Enable table: off, always on, or following the gate value.
  assign count_en = timer_on_bit & (~gate_enable_bit | gate_value);
  assign inc = count_en & src_tick & presc_hit;

  // Live count; a software byte write overrides a same-cycle increment.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= RESET_COUNT;
    end else if (wr_take && avs_address_in == ADDR_COUNT_LOW) begin
      count[7:0] <= avs_writedata_in[7:0];
    end else if (wr_take && avs_address_in == ADDR_COUNT_HIGH) begin
      count[15:8] <= avs_writedata_in[7:0];
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // Gate source and polarity: gate_pol is high while the chosen source is at the counting level.
  assign byte_timer_wrap_pulse = byte_timer_prev == BYTE_TIMER_MAX && byte_timer_count_in == BYTE_TIMER_MIN;
  assign gate_src = gate_source_select ? byte_timer_wrap_pulse : gate_level;
  assign gate_pol = gate_polarity_bit ? gate_src : ~gate_src;

  // Toggle flip-flop, forced clear while toggle mode is off so the measured edge is known.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      toggle_ff <= 1'b0;
      gate_pol_prev <= 1'b0;
    end else begin
      gate_pol_prev <= gate_pol;
      if (!toggle_mode_enable) begin
        toggle_ff <= 1'b0;
      end else if (gate_pol && !gate_pol_prev) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end

  assign toggle_out = toggle_mode_enable ? toggle_ff : gate_pol;

  // Single-pulse control; with toggle on, the window spans one full period of the source.
  always_comb begin
    next_sp_state = sp_state;
    sp_done = 1'b0;
    case (sp_state)
      SP_IDLE: begin
        if (single_pulse_enable && pulse_go_bit && !toggle_out) begin
          next_sp_state = SP_ARMED;
        end
      end
      SP_ARMED: begin
        if (!single_pulse_enable || !pulse_go_bit) begin
          next_sp_state = SP_IDLE;
        end else if (toggle_out && !toggle_prev) begin
          next_sp_state = SP_COUNT;
        end
      end
      SP_COUNT: begin
        if (!single_pulse_enable || !pulse_go_bit) begin
          next_sp_state = SP_IDLE;
        end else if (!toggle_out) begin
          next_sp_state = SP_IDLE;
          sp_done = 1'b1;
        end
      end
      default: next_sp_state = SP_IDLE;
    endcase
  end

  // Single-pulse state and the edge history of the gate path.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sp_state <= SP_IDLE;
      toggle_prev <= 1'b0;
      gate_value_prev <= 1'b0;
    end else begin
      sp_state <= next_sp_state;
      toggle_prev <= toggle_out;
      gate_value_prev <= gate_value;
    end
  end

  // Gate value is valid even when gating is disabled.
  assign gate_value = single_pulse_enable ? (sp_state == SP_COUNT && toggle_out) : toggle_out;

  // Status outputs from flops, except the gate value which mirrors the live gate path.
  assign overflow_flag_out = overflow_flag;
  assign gate_event_flag_out = gate_event_flag;
  assign gate_value_out = gate_value;

  // Checks on the design's own signals.
  a_off_holds: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !timer_on_bit && !wr_take |=> $stable(count))
    else $error("Count moved while timer off.");
  a_sys_rate: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    timer_on_bit && !gate_enable_bit && clock_select_field == CLK_SYS && prescale_field == 2'h0 && !sleep_in
      && !wr_take |=> count == $past(count) + 16'h0001)
    else $error("System clock source did not count each cycle.");
  a_byte_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    wr_take && avs_address_in == ADDR_COUNT_LOW |=> count[7:0] == $past(avs_writedata_in[7:0]))
    else $error("Low byte write not applied.");
  a_presc_clear: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    wr_take && avs_address_in == ADDR_COUNT_HIGH |=> presc_cnt == 3'h0)
    else $error("Prescaler not cleared by count write.");
  a_overflow_set: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    inc && count == COUNT_MAX && !wr_take |=> overflow_flag && count == RESET_COUNT)
    else $error("Wrap did not set overflow flag.");
  a_toggle_clear: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !toggle_mode_enable |=> !toggle_ff)
    else $error("Toggle flip-flop not held clear.");
  a_ext_armed: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    clock_select_field == CLK_EXT && !ext_armed |-> !inc)
    else $error("External edge counted before a falling edge.");
  a_go_done: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    sp_state == SP_COUNT && single_pulse_enable && pulse_go_bit && !toggle_out && !wr_gate_ctrl
      |=> !pulse_go_bit ##1 sp_state != SP_COUNT)
    else $error("Go bit not cleared at trailing edge.");
  a_gate_event: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $fell(gate_value) |=> gate_event_flag)
    else $error("Falling gate value did not set event flag.");
  a_gate_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    gate_enable_bit && !gate_value && !wr_take |=> $stable(count))
    else $error("Count moved while gate closed.");
  a_wait_once: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    acc_req && !ack |=> !avs_waitrequest_out)
    else $error("Waitrequest held longer than one cycle.");

  c_overflow: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) $rose(overflow_flag));
  c_single_pulse: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) sp_done);
  c_toggle: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) toggle_mode_enable && $rose(toggle_ff));
  c_ext_count: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) inc && clock_select_field == CLK_EXT);
endmodule // gated_timer_counter

// file: tb/gtc_far_side.sv
// Far-side model: external count clock, gate pin, byte timer and slow oscillator.
// Assumes the bench asks for bursts by level and that all pins move on sys_clk.
`timescale 1ns/100ps
module gtc_far_side (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic ext_run_in,
  input wire logic byte_run_in,
  input wire logic gate_level_in,
  output logic ext_clock_pin_out,
  output logic gate_pin_out,
  output logic lf_osc_out,
  output logic [7:0] byte_count_out
);
  logic [3:0] phase;
  logic [3:0] lf_div;
  // Pin clock of eight cycles; parked low between bursts, never free-running.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase <= 4'h0;
      ext_clock_pin_out <= 1'b0;
    end else if (!ext_run_in) begin
      phase <= 4'h0;
      ext_clock_pin_out <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      if (phase[1:0] == 2'h3) ext_clock_pin_out <= ~ext_clock_pin_out;
    end
  end
  // Byte timer steps while asked, so it passes from its top value to zero.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      byte_count_out <= 8'h00;
      lf_div <= 4'h0;
      gate_pin_out <= 1'b0;
    end else begin
      if (byte_run_in) byte_count_out <= byte_count_out + 8'h01;
      lf_div <= lf_div + 4'h1;
      gate_pin_out <= gate_level_in;
    end
  end
  assign lf_osc_out = lf_div[3];
endmodule // gtc_far_side

// file: tb/gated_timer_counter_tb.sv
// Self-checking bench for the gated 16-bit timer/counter.
// Assumes the far-side model drives the pins and the bus answers with waitrequest.
`timescale 1ns/100ps
module gated_timer_counter_tb;
  import gtc_pkg::*;
  logic sys_clk_in = 0, resetn_in = 0, rd = 0, wr = 0, sleep = 0;
  logic ext_run = 0, byte_run = 0, gate_lvl = 0, wait_o, ovf, gev, gval, ext_pin, gpin, lf;
  logic [4:0] addr = '0;
  logic [31:0] wd = '0, rdata, q, x;
  logic [3:0] be = 4'h1;
  logic [7:0] bcount;
  int failures = 0, check_count = 0, cycles = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  gated_timer_counter gated_timer_counter_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .ext_clock_pin_in(ext_pin), .gate_pin_in(gpin), .low_freq_internal_osc_in(lf),
    .byte_timer_count_in(bcount), .sleep_in(sleep), .overflow_flag_out(ovf),
    .gate_event_flag_out(gev), .gate_value_out(gval));
  gtc_far_side gtc_far_side_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ext_run_in(ext_run),
    .byte_run_in(byte_run), .gate_level_in(gate_lvl), .ext_clock_pin_out(ext_pin),
    .gate_pin_out(gpin), .lf_osc_out(lf), .byte_count_out(bcount));
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task idle(int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Bus cycles hold the request until waitrequest is sampled low, then release.
  task bus_wr(logic [4:0] a, logic [7:0] d);
    addr <= a;
    wd <= 32'(d);
    wr <= 1'b1;
    do @(posedge sys_clk_in); while (wait_o !== 1'b0);
    wr <= 1'b0;
    idle(1);
  endtask
  task bus_rd(logic [4:0] a);
    addr <= a;
    rd <= 1'b1;
    do @(posedge sys_clk_in); while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    idle(1);
  endtask
  task zero_count;
    bus_wr(ADDR_COUNT_LOW, 8'h00);
    bus_wr(ADDR_COUNT_HIGH, 8'h00);
  endtask
  task pulse(int n);
    gate_lvl <= 1'b1;
    idle(n);
    gate_lvl <= 1'b0;
    idle(8);
  endtask
  task t_regs;
    bus_rd(ADDR_TIMER_CONTROL); check("ctrl_rst", q, '0);
    bus_rd(ADDR_FLAGS); check("flags_rst", q, '0);
    bus_rd(5'h14); check("unmapped", q, '0);
    bus_wr(ADDR_COUNT_LOW, 8'h5A);
    be <= 4'h0;
    bus_wr(ADDR_COUNT_LOW, 8'hA5);
    be <= 4'h1;
    bus_rd(ADDR_COUNT_LOW); check("cnt_lo", q, 32'h0000_005A);
    $display("done regs");
  endtask
  // Count writes happen with the timer stopped, so no count write races an increment.
  task t_sys;
    bus_wr(ADDR_COUNT_HIGH, 8'hFF);
    bus_wr(ADDR_COUNT_LOW, 8'hF0);
    bus_wr(ADDR_TIMER_CONTROL, 8'h71);
    idle(40);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    bus_rd(ADDR_COUNT_HIGH); check("div8_hi", q, 32'h0000_00FF);
    bus_rd(ADDR_COUNT_LOW); x = q;
    idle(20);
    bus_rd(ADDR_COUNT_LOW); check("off_hold", q, x);
    bus_wr(ADDR_TIMER_CONTROL, 8'h41);
    idle(40);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    bus_rd(ADDR_COUNT_HIGH); check("wrap_hi", q, '0);
    check("ovf", ovf, 1'b1);
    bus_wr(ADDR_FLAGS, 8'h01);
    bus_rd(ADDR_FLAGS); check("ovf_clr", q, '0);
    $display("done sys");
  endtask
  task t_gate;
    zero_count();
    bus_wr(ADDR_GATE_CONTROL, 8'hC0);
    bus_wr(ADDR_TIMER_CONTROL, 8'h41);
    idle(20);
    bus_rd(ADDR_COUNT_LOW); check("gate_hold", q, '0);
    check("gval_lo", gval, 1'b0);
    // The polarity write above already made a falling gate value, so clear that event first.
    bus_wr(ADDR_FLAGS, 8'h02);
    check("gev_pre", gev, 1'b0);
    pulse(20);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    bus_rd(ADDR_COUNT_LOW); check("gate_ran", q == '0, 1'b0);
    check("gev", gev, 1'b1);
    bus_wr(ADDR_FLAGS, 8'h02);
    bus_wr(ADDR_GATE_CONTROL, 8'h41);
    check("gev_clr", gev, 1'b0);
    byte_run <= 1'b1;
    idle(300);
    byte_run <= 1'b0;
    idle(6);
    check("wrap_event", gev, 1'b1);
    bus_wr(ADDR_FLAGS, 8'h02);
    // Toggle is enabled only after polarity has settled in an earlier write.
    bus_wr(ADDR_GATE_CONTROL, 8'h40);
    bus_wr(ADDR_GATE_CONTROL, 8'h60);
    pulse(6);
    check("toggle_hi", gval, 1'b1);
    bus_wr(ADDR_GATE_CONTROL, 8'h40);
    bus_wr(ADDR_GATE_CONTROL, 8'h60);
    check("toggle_clr", gval, 1'b0);
    $display("done gate");
  endtask
  // Five pin pulses after a count write: the first rise lacks a prior fall.
  task t_ext;
    for (int s = 0; s < 2; s++) begin
      sleep <= s[0];
      zero_count();
      bus_wr(ADDR_TIMER_CONTROL, {4'h8, 1'b0, s[0], 2'h1});
      ext_run <= 1'b1;
      idle(40);
      ext_run <= 1'b0;
      idle(8);
      bus_wr(ADDR_TIMER_CONTROL, 8'h00);
      sleep <= 1'b0;
      bus_rd(ADDR_COUNT_LOW); check("ext_count", q, 32'h0000_0004);
    end
    $display("done ext");
  endtask
  task t_pulse;
    zero_count();
    bus_wr(ADDR_GATE_CONTROL, 8'hD0);
    bus_wr(ADDR_TIMER_CONTROL, 8'h41);
    bus_wr(ADDR_GATE_CONTROL, 8'hD8);
    pulse(10);
    bus_rd(ADDR_GATE_CONTROL); check("go_done", q[GC_GO], 1'b0);
    bus_rd(ADDR_COUNT_LOW); x = q;
    check("pulse_ran", x == '0, 1'b0);
    pulse(10);
    bus_rd(ADDR_COUNT_LOW); check("pulse_ignored", q, x);
    // Toggle joins single pulse with polarity unchanged; the window then spans two gate rises.
    bus_wr(ADDR_GATE_CONTROL, 8'hF0);
    bus_wr(ADDR_GATE_CONTROL, 8'hF8);
    pulse(10);
    bus_rd(ADDR_GATE_CONTROL); check("full_armed", q[GC_GO], 1'b1);
    pulse(10);
    bus_rd(ADDR_GATE_CONTROL); check("full_done", q[GC_GO], 1'b0);
    bus_wr(ADDR_GATE_CONTROL, 8'h00);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    $display("done pulse");
  endtask
  // The timer runs for whole source periods: 44 edges hold 11 instruction ticks, 48 edges 3 oscillator rises.
  task t_src;
    zero_count();
    bus_wr(ADDR_TIMER_CONTROL, 8'h01);
    idle(41);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    bus_rd(ADDR_COUNT_LOW); check("instr_rate", q, 32'(44 / INSTR_DIV_CYCLES));
    zero_count();
    bus_wr(ADDR_TIMER_CONTROL, 8'hC1);
    idle(45);
    bus_wr(ADDR_TIMER_CONTROL, 8'h00);
    bus_rd(ADDR_COUNT_LOW); check("lfosc_rate", q, 32'h0000_0003);
    $display("done src");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang is cut short well past the roughly one thousand cycles the run needs.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    idle(4);
    resetn_in <= 1'b1;
    t_regs();
    t_sys();
    t_gate();
    t_ext();
    t_pulse();
    t_src();
    end_sim();
  end
endmodule // gated_timer_counter_tb
